// >>> hw/synth_config_register_command_unit.sv
// serial register set and command decoder of a clock synthesizer.
// assumes scl, sda and all pins come from outside the clock domain;
// the pll itself, its lock detector and the startup pin load live outside.
// What this block does
// - in serial mode active dividers change only on load and step commands
// - register contents persist across separate transactions
// - low register holds feedback divider bits 7..0
// - high register: fb 9:8, post a, b, pre, lock
// - lock bit mirrors pll lock, writes ignored
// - command register write-only, decoded not stored
// - low nibble 0001 increments active feedback divider
// - low nibble 0010 decrements active feedback divider
// - low nibble 0100 copies registers into active dividers
// - low nibble 1000 copies active dividers into registers
// - step commands leave registers and post dividers alone
// - no range checks on load or steps
// - parallel to serial keeps everything unchanged
// - serial to parallel: dividers follow pins at once
// - parallel mode mirrors config, readback unsupported
// - slave address: five fixed bits plus two pins
// - bit after address selects write or read
// - write: register address then data, pairs repeat
// - read returns low then high, no address phase
// - parallel mode acknowledges but discards written data
`timescale 1ns/1ps

module synth_config_register_command_unit (
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n_out,
	input  wire logic [1:0] addr_sel_in,
	input  wire logic       pin_programming_select_in,
	input  wire logic       pll_lock_in,
	input  wire logic [9:0] pin_feedback_in,
	input  wire logic [2:0] post_divider_a_code_in,
	input  wire logic       pin_post_b_in,
	input  wire logic       pin_pre_in,
	output logic [9:0]      active_feedback_out,
	output logic [2:0]      post_divider_a_code_out,
	output logic            active_post_b_out,
	output logic            active_pre_out
);

	// ==========================================================
	// declarations
	logic [synth_cfg_pkg::SYNC_WIDTH-1:0] meta_q;
	logic [synth_cfg_pkg::SYNC_WIDTH-1:0] sync_q;
	logic                      scl_s;
	logic                      sda_s;
	logic                      mode_s;
	logic                      lock_s;
	logic [1:0]                addr_s;
	logic [9:0]                pin_fb_s;
	logic [2:0]                pin_pa_s;
	logic                      pin_pb_s;
	logic                      pin_pre_s;
	logic                      scl_prev_q;
	logic                      sda_prev_q;
	logic                      scl_rise;
	logic                      scl_fall;
	logic                      start_cond;
	logic                      stop_cond;
	synth_cfg_pkg::link_state_t state_q;
	logic [3:0]                cnt_q;
	logic [7:0]                shift_q;
	logic [1:0]                kind_q;
	logic                      rw_q;
	logic [7:0]                reg_addr_q;
	logic                      rd_sel_q;
	logic                      sda_oe_n_q;
	logic                      sda_level_q;
	logic                      byte_done;
	logic                      addr_match;
	logic                      wr_strobe;
	logic                      do_up;
	logic                      do_down;
	logic                      do_load;
	logic                      do_get;
	logic [7:0]                low_q;
	logic [7:1]                high_q;
	logic [9:0]                act_fb_q;
	logic [2:0]                act_pa_q;
	logic                      act_pb_q;
	logic                      act_pre_q;
	logic [7:0]                send_byte;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	// ==========================================================
	// decoding helpers
	// true when a data byte to the command register carries this code
	function automatic logic op_hit(input logic strobe, input logic [7:0] addr,
		input logic [7:0] data, input logic [3:0] code);
		op_hit = strobe && (addr == synth_cfg_pkg::REG_COMMAND) && (data[3:0] == code);
	endfunction

	// byte sent on a read: low register, or high register with live lock
	function automatic logic [7:0] read_byte(input logic sel, input logic [7:0] low,
		input logic [7:1] high, input logic lock);
		read_byte = sel ? {high, lock} : low;
	endfunction

	// ==========================================================
	// input synchronisers
	// two flops for every pin input; first stage feeds only the second
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= {scl_in, sda_in, pin_programming_select_in, pll_lock_in, addr_sel_in,
				pin_feedback_in, post_divider_a_code_in, pin_post_b_in, pin_pre_in};
			sync_q <= meta_q;
		end
	end

	// unpack the synchronised inputs
	assign {scl_s, sda_s, mode_s, lock_s, addr_s, pin_fb_s, pin_pa_s, pin_pb_s,
		pin_pre_s} = sync_q;

	// previous levels of the bus lines for edge and condition detection
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	// edges of scl, start and stop while scl is high
	assign scl_rise   = scl_s & ~scl_prev_q;
	assign scl_fall   = ~scl_s & scl_prev_q;
	assign start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_cond  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

	// ==========================================================
	// byte framing and strobes
	assign byte_done  = (state_q == synth_cfg_pkg::ST_RECV) && scl_fall &&
		(cnt_q == synth_cfg_pkg::BITS_PER_BYTE);
	assign addr_match = (shift_q[7:3] == synth_cfg_pkg::SLAVE_ADDR_FIXED) &&
		(shift_q[2:1] == addr_s);
	assign wr_strobe  = byte_done && (kind_q == synth_cfg_pkg::KIND_DATA) && mode_s;
	assign send_byte  = read_byte(rd_sel_q, low_q, high_q, lock_s);

	assign do_up   = op_hit(wr_strobe, reg_addr_q, shift_q, synth_cfg_pkg::OP_STEP_UP);
	assign do_down = op_hit(wr_strobe, reg_addr_q, shift_q, synth_cfg_pkg::OP_STEP_DOWN);
	assign do_load = op_hit(wr_strobe, reg_addr_q, shift_q, synth_cfg_pkg::OP_LOAD);
	assign do_get  = op_hit(wr_strobe, reg_addr_q, shift_q, synth_cfg_pkg::OP_READBACK);

	// ==========================================================
	// serial link state machine
	// data is sampled on scl rise and driven after scl fall
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_q    <= synth_cfg_pkg::ST_IDLE;
			cnt_q      <= 4'h0;
			shift_q    <= 8'h00;
			kind_q     <= synth_cfg_pkg::KIND_ADDR;
			rw_q       <= 1'b0;
			reg_addr_q <= 8'h00;
			rd_sel_q   <= 1'b0;
			sda_oe_n_q <= 1'b1;
		end else if (start_cond) begin
			state_q    <= synth_cfg_pkg::ST_RECV;
			cnt_q      <= 4'h0;
			kind_q     <= synth_cfg_pkg::KIND_ADDR;
			sda_oe_n_q <= 1'b1;
		end else if (stop_cond) begin
			state_q    <= synth_cfg_pkg::ST_IDLE;
			sda_oe_n_q <= 1'b1;
		end else begin
			case (state_q)
				synth_cfg_pkg::ST_RECV: begin
					if (scl_rise && (cnt_q != synth_cfg_pkg::BITS_PER_BYTE)) begin
						shift_q <= {shift_q[6:0], sda_s};
						cnt_q   <= cnt_q + 4'h1;
					end else if (byte_done) begin
						cnt_q <= 4'h0;
						case (kind_q)
							synth_cfg_pkg::KIND_ADDR: begin
								if (addr_match) begin
									state_q    <= synth_cfg_pkg::ST_ACK;
									sda_oe_n_q <= 1'b0;
									rw_q       <= shift_q[0];
									rd_sel_q   <= 1'b0;
									kind_q     <= synth_cfg_pkg::KIND_REG;
								end else begin
									state_q <= synth_cfg_pkg::ST_IDLE;
								end
							end
							synth_cfg_pkg::KIND_REG: begin
								reg_addr_q <= shift_q;
								kind_q     <= synth_cfg_pkg::KIND_DATA;
								state_q    <= synth_cfg_pkg::ST_ACK;
								sda_oe_n_q <= 1'b0;
							end
							// data byte, next pair may follow
							default: begin
								kind_q     <= synth_cfg_pkg::KIND_REG;
								state_q    <= synth_cfg_pkg::ST_ACK;
								sda_oe_n_q <= 1'b0;
							end
						endcase
					end
				end
				synth_cfg_pkg::ST_ACK: begin
					if (scl_fall) begin
						if (rw_q) begin
							state_q    <= synth_cfg_pkg::ST_SEND;
							shift_q    <= send_byte;
							sda_oe_n_q <= send_byte[7];
							cnt_q      <= 4'h1;
						end else begin
							state_q    <= synth_cfg_pkg::ST_RECV;
							sda_oe_n_q <= 1'b1;
						end
					end
				end
				synth_cfg_pkg::ST_SEND: begin
					if (scl_fall) begin
						if (cnt_q == synth_cfg_pkg::BITS_PER_BYTE) begin
							state_q    <= synth_cfg_pkg::ST_MACK;
							sda_oe_n_q <= 1'b1;
							rd_sel_q   <= ~rd_sel_q;
						end else begin
							sda_oe_n_q <= shift_q[6];
							shift_q    <= {shift_q[6:0], 1'b0};
							cnt_q      <= cnt_q + 4'h1;
						end
					end
				end
				synth_cfg_pkg::ST_MACK: begin
					// master ack continues the read, nack ends it
					if (scl_rise) begin
						state_q <= sda_s ? synth_cfg_pkg::ST_IDLE : synth_cfg_pkg::ST_ACK;
					end
				end
				default: begin
					state_q    <= synth_cfg_pkg::ST_IDLE;
					sda_oe_n_q <= 1'b1;
				end
			endcase
		end
	end

	// open-drain data line only ever pulls low
	always_ff @(posedge clk_in) begin
		sda_level_q <= 1'b0;
	end

	// ==========================================================
	// configuration registers
	// contents held between transfers
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			low_q  <= synth_cfg_pkg::RST_FEEDBACK[7:0];
			high_q <= {synth_cfg_pkg::RST_FEEDBACK[9:8], synth_cfg_pkg::RST_POST_A,
				synth_cfg_pkg::RST_POST_B, synth_cfg_pkg::RST_PRE};
		end else if (!mode_s) begin
			low_q  <= pin_fb_s[7:0];
			high_q <= {pin_fb_s[9:8], pin_pa_s, pin_pb_s, pin_pre_s};
		end else if (wr_strobe && (reg_addr_q == synth_cfg_pkg::REG_FB_LOW)) begin
			low_q <= shift_q;
		end else if (wr_strobe && (reg_addr_q == synth_cfg_pkg::REG_DIV_HIGH)) begin
			high_q <= shift_q[7:1];
		end else if (do_get) begin
			low_q  <= act_fb_q[7:0];
			high_q <= {act_fb_q[9:8], act_pa_q, act_pb_q, act_pre_q};
		end
	end

	// ==========================================================
	// active pll dividers
	// mode change to serial keeps values
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			act_fb_q  <= synth_cfg_pkg::RST_FEEDBACK;
			act_pa_q  <= synth_cfg_pkg::RST_POST_A;
			act_pb_q  <= synth_cfg_pkg::RST_POST_B;
			act_pre_q <= synth_cfg_pkg::RST_PRE;
		end else if (!mode_s) begin
			act_fb_q  <= pin_fb_s;
			act_pa_q  <= pin_pa_s;
			act_pb_q  <= pin_pb_s;
			act_pre_q <= pin_pre_s;
		end else if (do_load) begin
			act_fb_q  <= {high_q[synth_cfg_pkg::HIGH_FB_MSB:synth_cfg_pkg::HIGH_FB_LSB], low_q};
			act_pa_q  <= high_q[synth_cfg_pkg::HIGH_POSTA_MSB:synth_cfg_pkg::HIGH_POSTA_LSB];
			act_pb_q  <= high_q[synth_cfg_pkg::HIGH_POSTB_POS];
			act_pre_q <= high_q[synth_cfg_pkg::HIGH_PRE_POS];
		end else if (do_up) begin
			act_fb_q <= act_fb_q + 10'h001;
		end else if (do_down) begin
			act_fb_q <= act_fb_q - 10'h001;
		end
	end

	// ==========================================================
	// outputs
	// command byte never stored
	assign sda_out                 = sda_level_q;
	assign sda_oe_n_out            = sda_oe_n_q;
	assign active_feedback_out     = act_fb_q;
	assign post_divider_a_code_out = act_pa_q;
	assign active_post_b_out       = act_pb_q;
	assign active_pre_out          = act_pre_q;

	// ==========================================================
	// checks
	sequence step_up_seen;
		do_up;
	endsequence

	sequence step_down_seen;
		do_down;
	endsequence

	sequence cfg_write_seen;
		wr_strobe && ((reg_addr_q == synth_cfg_pkg::REG_FB_LOW) ||
			(reg_addr_q == synth_cfg_pkg::REG_DIV_HIGH));
	endsequence

	cfg_write_hold_a: assert property (cfg_write_seen |=> $stable(act_fb_q) && $stable(act_pa_q))
		else $error("config write changed active dividers");
	step_up_a: assert property (step_up_seen |=> act_fb_q == $past(act_fb_q) + 10'h001)
		else $error("step up did not add one");
	step_down_a: assert property (step_down_seen |=> act_fb_q == $past(act_fb_q) - 10'h001)
		else $error("step down did not subtract one");
	load_copy_a: assert property (do_load |=> act_fb_q == {$past(high_q[7:6]), $past(low_q)})
		else $error("load did not copy registers");
	get_copy_a: assert property (do_get |=> {high_q[7:6], low_q} == $past(act_fb_q) &&
		high_q[5:1] == {$past(act_pa_q), $past(act_pb_q), $past(act_pre_q)})
		else $error("readback did not copy dividers");
	step_keeps_cfg_a: assert property ((do_up || do_down) |=>
		$stable(low_q) && $stable(high_q) && $stable(act_pa_q) && $stable(act_pre_q))
		else $error("step command touched registers");
	pin_follow_a: assert property (!mode_s |=> act_fb_q == $past(pin_fb_s) &&
		act_pa_q == $past(pin_pa_s))
		else $error("parallel mode not following pins");
	addr_ack_a: assert property (byte_done && kind_q == synth_cfg_pkg::KIND_ADDR && addr_match
		&& !start_cond && !stop_cond |=> !sda_oe_n_q)
		else $error("matching address not acknowledged");
	bad_op_a: assert property (wr_strobe && reg_addr_q == synth_cfg_pkg::REG_COMMAND &&
		!(do_up || do_down || do_load || do_get) |=> $stable(act_fb_q) && $stable(low_q))
		else $error("unknown command had an effect");
endmodule

// >>> include/synth_cfg_pkg.sv
// constants, field layout and state codes of the synthesizer
// configuration register and command unit.
// assumes a single 100 MHz system clock in the using module.
package synth_cfg_pkg;

	// ==========================================================
	// register addresses
	localparam logic [7:0] REG_FB_LOW   = 8'h00;
	localparam logic [7:0] REG_DIV_HIGH = 8'h01;
	localparam logic [7:0] REG_COMMAND  = 8'hF0;

	// ==========================================================
	// command codes, low nibble of the command byte
	localparam logic [3:0] OP_STEP_UP   = 4'h1;
	localparam logic [3:0] OP_STEP_DOWN = 4'h2;
	localparam logic [3:0] OP_LOAD      = 4'h4;
	localparam logic [3:0] OP_READBACK  = 4'h8;

	// ==========================================================
	// field positions in the high register
	localparam int HIGH_FB_MSB    = 7;
	localparam int HIGH_FB_LSB    = 6;
	localparam int HIGH_POSTA_MSB = 5;
	localparam int HIGH_POSTA_LSB = 3;
	localparam int HIGH_POSTB_POS = 2;
	localparam int HIGH_PRE_POS   = 1;

	// ==========================================================
	// values after reset
	localparam logic [9:0] RST_FEEDBACK = 10'h1F4;
	localparam logic [2:0] RST_POST_A   = 3'h2;
	localparam logic       RST_POST_B   = 1'h0;
	localparam logic       RST_PRE      = 1'h1;

	// ==========================================================
	// serial slave address and framing
	localparam logic [4:0] SLAVE_ADDR_FIXED = 5'h16;
	localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
	localparam int         SYNC_WIDTH       = 21;

	// byte kinds inside a write transfer
	localparam logic [1:0] KIND_ADDR = 2'h0;
	localparam logic [1:0] KIND_REG  = 2'h1;
	localparam logic [1:0] KIND_DATA = 2'h2;

	// ==========================================================
	// serial link state machine
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_RECV = 5'b00010,
		ST_ACK  = 5'b00100,
		ST_SEND = 5'b01000,
		ST_MACK = 5'b10000
	} link_state_t;

endpackage

// >>> testbench/i2c_host_model.sv
// two-wire bus controller model: drives the clock and pulls data low.
// assumes the bench resolves the data wire with a pull-up from all drivers.
`timescale 1ns/1ps

module i2c_host_model (
	input  wire logic clk_in,
	input  wire logic sda_wire_in,
	output logic      scl_out,
	output logic      sda_low_out
);
	// ==========================================================
	// idle: clock stands high, data released to the pull-up
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end

	// alternating 12 and 13 clock bits average a 125 ns link period
	logic long_bit = 1'b0;

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	// start or repeated start, leaves the clock low
	task automatic start_cond();
		tick(3);
		sda_low_out <= 1'b0;
		tick(3);
		scl_out <= 1'b1;
		tick(6);
		sda_low_out <= 1'b1;
		tick(6);
		scl_out <= 1'b0;
	endtask

	// one bit: data set mid-low, sampled mid-high, 125 ns per bit on average
	task automatic clock_bit(input logic b, output logic s);
		tick(3);
		sda_low_out <= ~b;
		tick(3);
		scl_out <= 1'b1;
		tick(4);
		s = sda_wire_in;
		long_bit = ~long_bit;
		tick(long_bit ? 3 : 2);
		scl_out <= 1'b0;
	endtask

	// byte msb first, then the slave acknowledge slot
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(d[i], s);
		end
		clock_bit(1'b1, s);
		ack = ~s;
	endtask

	task automatic send_addr(input logic [6:0] slave, input logic rd, output logic ack);
		send_byte({slave, rd}, ack);
	endtask

	// byte from the slave, then our acknowledge or not
	task automatic recv_byte(output logic [7:0] d, input logic ack_me);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(1'b1, s);
			d[i] = s;
		end
		clock_bit(~ack_me, s);
	endtask

	// stop: data rises while the clock is high
	task automatic stop_cond();
		tick(3);
		sda_low_out <= 1'b1;
		tick(3);
		scl_out <= 1'b1;
		tick(6);
		sda_low_out <= 1'b0;
		tick(6);
	endtask
endmodule

// >>> testbench/tb.sv
// self-checking bench for the synthesizer register and command unit.
// assumes the host model above and an open-drain data wire with pull-up.
`timescale 1ns/1ps

module tb;
	logic       clk_in, reset_in, scl, sda_low, sda_out, sda_oe_n_out;
	logic       pll_lock_in, mode, pin_b, pin_pre, active_post_b_out, active_pre_out;
	logic [1:0] addr_sel_in;
	logic [9:0] pin_fb, active_feedback_out;
	logic [2:0] pin_a, post_divider_a_code_out;
	logic [7:0] wq[$];
	logic [7:0] lo, hi;
	logic [7:0] ops[4] = '{8'hA1, 8'h02, 8'h03, 8'h00};
	logic [9:0] efb[4] = '{10'h335, 10'h334, 10'h334, 10'h334};
	int         miscompares, check_count, cycles;
	wire logic  sda_wire = ~sda_low & (sda_oe_n_out | sda_out);

	synth_config_register_command_unit synth_config_register_command_unit_inst (
		.clk_in(clk_in), .reset_in(reset_in), .scl_in(scl), .sda_in(sda_wire),
		.sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .addr_sel_in(addr_sel_in),
		.pin_programming_select_in(mode), .pll_lock_in(pll_lock_in),
		.pin_feedback_in(pin_fb), .post_divider_a_code_in(pin_a),
		.pin_post_b_in(pin_b), .pin_pre_in(pin_pre),
		.active_feedback_out(active_feedback_out),
		.post_divider_a_code_out(post_divider_a_code_out),
		.active_post_b_out(active_post_b_out), .active_pre_out(active_pre_out));

	i2c_host_model i2c_host_model_inst (
		.clk_in(clk_in), .sda_wire_in(sda_wire), .scl_out(scl), .sda_low_out(sda_low));

	// ==========================================================
	// clock and cycle ceiling
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			miscompares++;
			tally_and_finish();
		end
	end

	// ==========================================================
	// helpers
	task automatic tally_and_finish();
		if (miscompares == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	function automatic logic [15:0] cfg(logic [9:0] fb, logic [2:0] a, logic b, logic p);
		return {1'b0, fb, a, b, p};
	endfunction

	function automatic logic [15:0] act();
		return cfg(active_feedback_out, post_divider_a_code_out, active_post_b_out,
			active_pre_out);
	endfunction

	function automatic logic [7:0] hb(logic [9:0] fb, logic [2:0] a, logic b, logic p,
			logic l);
		return {fb[9:8], a, b, p, l};
	endfunction

	// write transfer of the queued register/data pairs
	task automatic send_w(input logic [1:0] sel, input logic exp_ack);
		logic a;
		i2c_host_model_inst.start_cond();
		i2c_host_model_inst.send_addr({synth_cfg_pkg::SLAVE_ADDR_FIXED, sel}, 1'b0, a);
		chk("address ack", {15'h0, exp_ack}, {15'h0, a});
		if (exp_ack) begin
			foreach (wq[i]) begin
				i2c_host_model_inst.send_byte(wq[i], a);
				chk("byte ack", 16'h0001, {15'h0, a});
			end
		end
		i2c_host_model_inst.stop_cond();
	endtask

	// read transfer: low then high, no register address
	task automatic rd(input logic [7:0] elo, input logic [7:0] ehi);
		logic a;
		i2c_host_model_inst.start_cond();
		i2c_host_model_inst.send_addr({synth_cfg_pkg::SLAVE_ADDR_FIXED, addr_sel_in}, 1'b1, a);
		chk("read ack", 16'h0001, {15'h0, a});
		i2c_host_model_inst.recv_byte(lo, 1'b1);
		i2c_host_model_inst.recv_byte(hi, 1'b0);
		i2c_host_model_inst.stop_cond();
		chk("low reg", {8'h0, elo}, {8'h0, lo});
		chk("high reg", {8'h0, ehi}, {8'h0, hi});
	endtask

	// ==========================================================
	// main sequence
	initial begin
		reset_in = 1'b1;
		mode = 1'b0;
		pll_lock_in = 1'b1;
		addr_sel_in = 2'h2;
		pin_fb = 10'h2A5;
		pin_a = 3'h5;
		pin_b = 1'b1;
		pin_pre = 1'b0;
		repeat (16) @(posedge clk_in);
		reset_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		chk("active", cfg(10'h2A5, 3'h5, 1'b1, 1'b0), act());
		rd(8'hA5, hb(10'h2A5, 3'h5, 1'b1, 1'b0, 1'b1));
		wq = '{8'h00, 8'h11, 8'hF0, 8'h08};
		send_w(2'h2, 1'b1);
		rd(8'hA5, hb(10'h2A5, 3'h5, 1'b1, 1'b0, 1'b1));
		mode <= 1'b1;
		repeat (5) @(posedge clk_in);
		pin_fb <= 10'h0F0;
		repeat (5) @(posedge clk_in);
		chk("active", cfg(10'h2A5, 3'h5, 1'b1, 1'b0), act());
		rd(8'hA5, hb(10'h2A5, 3'h5, 1'b1, 1'b0, 1'b1));
		pll_lock_in <= 1'b0;
		wq = '{8'h00, 8'h34, 8'h01, 8'hC9};
		send_w(2'h2, 1'b1);
		chk("active", cfg(10'h2A5, 3'h5, 1'b1, 1'b0), act());
		rd(8'h34, 8'hC8);
		wq = '{8'hF0, 8'hF4};
		send_w(2'h2, 1'b1);
		chk("active", cfg(10'h334, 3'h1, 1'b0, 1'b0), act());
		foreach (ops[i]) begin
			wq = '{8'hF0, ops[i]};
			send_w(2'h2, 1'b1);
			chk("active", cfg(efb[i], 3'h1, 1'b0, 1'b0), act());
		end
		rd(8'h34, 8'hC8);
		wq = '{8'h00, 8'hFF, 8'h01, 8'hC8, 8'hF0, 8'h04, 8'hF0, 8'h01};
		send_w(2'h2, 1'b1);
		chk("active", cfg(10'h000, 3'h1, 1'b0, 1'b0), act());
		wq = '{8'h55, 8'h77, 8'hF0, 8'h18};
		send_w(2'h2, 1'b1);
		rd(8'h00, 8'h08);
		wq = '{8'hF0, 8'h02};
		send_w(2'h2, 1'b1);
		chk("active", cfg(10'h3FF, 3'h1, 1'b0, 1'b0), act());
		wq = '{8'hF0, 8'h04};
		send_w(2'h1, 1'b0);
		chk("active", cfg(10'h3FF, 3'h1, 1'b0, 1'b0), act());
		mode <= 1'b0;
		repeat (5) @(posedge clk_in);
		chk("active", cfg(10'h0F0, 3'h5, 1'b1, 1'b0), act());
		pin_a <= 3'h3;
		repeat (5) @(posedge clk_in);
		chk("active", cfg(10'h0F0, 3'h3, 1'b1, 1'b0), act());
		rd(8'hF0, hb(10'h0F0, 3'h3, 1'b1, 1'b0, 1'b0));
		tally_and_finish();
	end
endmodule
